// file: rtl/lkcal_map.vh
`ifndef LKCAL_MAP_VH
`define LKCAL_MAP_VH
// How it works
// RULE1: Status pin selector 0 gives serial readback, 1 gives lock indication.
// RULE2: Lock type 0 uses calibration status, 1 uses tuning-voltage monitor.
// RULE3: Lock delay field spans 0..65535, counted in state machine ticks.
// RULE4: Calibration-status lock stays low during calibration and delay count after it.
// RULE5: Mute enabled switches outputs off while lock is low; disabled never mutes.
// RULE6: Tuning-voltage mode drives lock high when locked; readback reports state 2.
// RULE7: Lock status readable in a status field and on the pin.
// RULE8: Readback mode shifts register, lock and calibration results out on pin.
// RULE9: Writing control register zero with calibration enable set starts band calibration.
// RULE10: Every write to control register zero runs amplitude calibration; the code skips it when all three force bits are set.
// RULE11: Host keeps reference clock running before triggering calibration.
// RULE12: No force or quick bits: start from programmed core, amplitude, capcode.
// RULE13: Host should program core 7, amplitude 300, capcode 183 normally.
// RULE14: Host programs core 4 for targets between 11.9 and 12.1 GHz.
// RULE15: Partial assist: host writes start values before each trigger, forces cleared.
// RULE16: Quick recal starts from current capcode and amplitude start value.
// RULE17: All three force bits set apply host values directly, no search.
// RULE18: Host interpolates only between points on one core within 5MHz.
// RULE19: State machine tick is reference divided by 2 to the divide field.
// RULE20: Host uses no assist at 11900..12100 MHz: core 4, amplitude 300, capcode 1.
// RULE21: New calibration restarts delay counter; lock low until both finish.

// Register word offsets (byte address bits 4:2)
`define LKCAL_OFS_CTRL0 4'h0
`define LKCAL_OFS_CFG 4'h1
`define LKCAL_OFS_DELAY 4'h2
`define LKCAL_OFS_START 4'h3
`define LKCAL_OFS_FORCE 4'h4
`define LKCAL_OFS_STATUS 4'h5
`define LKCAL_OFS_RBSEL 4'h6
// CTRL0 fields
`define LKCAL_CAL_EN_BIT 0
// CFG fields
`define LKCAL_PIN_SEL_BIT 0
`define LKCAL_LOCK_DETECT_TYPE_BIT 1
`define LKCAL_MUTE_BIT 2
`define LKCAL_DIV_LSB 4
`define LKCAL_QUICK_BIT 8
`define LKCAL_CORE_F_BIT 9
`define LKCAL_AMP_F_BIT 10
`define LKCAL_CAP_F_BIT 11
// START and FORCE fields
`define LKCAL_CORE_LSB 0
`define LKCAL_CAP_LSB 8
`define LKCAL_AMP_LSB 16
// Reset values
`define LKCAL_CFG_RST 32'h0000_0000
`define LKCAL_DELAY_RST 16'h0000
`define LKCAL_START_RST 32'h012c_b707
`define LKCAL_FORCE_RST 32'h012c_b707
// Lock readback codes
`define LKCAL_LOCK_STATE_YES 2'h2
`define LKCAL_LOCK_STATE_NO 2'h0
// Search step limit per calibration phase
`define LKCAL_STEP_LIMIT 9'h1ff
// Clocks a new code needs to reach the synchronised comparators
`define LKCAL_SETTLE 4'h8
`endif

// file: rtl/lkcal_top.v
// Implementation choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "lkcal_map.vh"

module lkcal_top #(
	parameter DELAY_W = 16,
	parameter AMP_W = 9,
	parameter CAP_W = 8,
	parameter CORE_W = 3
) (
	input wire clk_i,
	input wire rst_i,
	input wire [4:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	input wire [3:0] avs_byteenable_i,
	output reg [31:0] avs_readdata_o,
	output wire avs_waitrequest_o,
	input wire osc_fast_i,
	input wire amp_high_i,
	input wire vtune_lock_i,
	output reg [CORE_W-1:0] osc_core_o,
	output reg [CAP_W-1:0] osc_capcode_o,
	output reg [AMP_W-1:0] osc_amplitude_o,
	output reg cal_busy_o,
	output reg out_mute_o,
	output reg status_pin_o
);

	// =========================================
	// Registers and state
	// =========================================
	localparam ST_IDLE = 2'h0;
	localparam ST_FREQ = 2'h1;
	localparam ST_AMP = 2'h2;

	reg ack_reg;
	reg ctrl0_reg;
	reg [31:0] cfg_reg;
	reg [DELAY_W-1:0] delay_reg;
	reg [31:0] start_reg;
	reg [31:0] force_reg;
	reg [3:0] rbsel_reg;
	reg [1:0] state_reg;
	reg [8:0] steps_reg;
	reg dir_reg;
	reg first_reg;
	reg [3:0] settle_reg;
	reg [DELAY_W-1:0] dcount_reg;
	reg drun_reg;
	reg [2:0] div_cnt_reg;
	reg [31:0] shift_reg;
	reg [5:0] shift_cnt_reg;
	reg [2:0] fast_sync_reg;
	reg [2:0] amp_sync_reg;
	reg [2:0] vt_sync_reg;
	reg fast_reg;
	reg amp_hi_reg;
	reg vt_reg;

	wire [31:0] be_mask;
	wire wr_ok;
	wire rd_ok;
	wire tick;
	wire settled;
	wire [1:0] div_sel;
	wire all_force;
	wire lock_ind;
	wire [1:0] lock_state;
	wire [3:0] reg_idx;
	reg [31:0] rd_mux;

	// =========================================
	// Avalon-MM slave
	// =========================================
	// One wait state on every access; keeps the read mux off the bus path
	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_reg;
	assign wr_ok = avs_write_i & ack_reg;
	assign rd_ok = avs_read_i & ~ack_reg;
	assign reg_idx = avs_address_i[4:2] == 3'h7 ? 4'hf : {1'b0, avs_address_i[4:2]};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_be
			assign be_mask[gi*8 +: 8] = {8{avs_byteenable_i[gi]}};
		end
	endgenerate

	// Ack toggles off the cycle after it was given
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= (avs_read_i | avs_write_i) & ~ack_reg;
		end
	end

	// Readback mux; unmapped offsets read zero
	always @* begin
		case (reg_idx)
			`LKCAL_OFS_CTRL0: rd_mux = {31'h0, ctrl0_reg};
			`LKCAL_OFS_CFG: rd_mux = cfg_reg;
			`LKCAL_OFS_DELAY: rd_mux = {{(32-DELAY_W){1'b0}}, delay_reg};
			`LKCAL_OFS_START: rd_mux = start_reg;
			`LKCAL_OFS_FORCE: rd_mux = force_reg;
			`LKCAL_OFS_STATUS: rd_mux = {7'h0, osc_amplitude_o, osc_capcode_o, 1'b0,
				osc_core_o, drun_reg, cal_busy_o, lock_state}; // RULE7 RULE8
			`LKCAL_OFS_RBSEL: rd_mux = {28'h0, rbsel_reg};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Read data captured on the same edge that drops waitrequest
	always @(posedge clk_i) begin
		if (rst_i) begin
			avs_readdata_o <= 32'h0000_0000;
		end else if (rd_ok) begin
			avs_readdata_o <= rd_mux;
		end
	end

	// Configuration writes with byte lanes
	always @(posedge clk_i) begin
		if (rst_i) begin
			ctrl0_reg <= 1'b0;
			cfg_reg <= `LKCAL_CFG_RST;
			delay_reg <= `LKCAL_DELAY_RST;
			start_reg <= `LKCAL_START_RST;
			force_reg <= `LKCAL_FORCE_RST;
			rbsel_reg <= 4'h0;
		end else if (wr_ok) begin
			case (reg_idx)
				`LKCAL_OFS_CTRL0: if (avs_byteenable_i[0]) begin
					ctrl0_reg <= avs_writedata_i[`LKCAL_CAL_EN_BIT];
				end
				`LKCAL_OFS_CFG: cfg_reg <= (cfg_reg & ~be_mask) | (avs_writedata_i & be_mask);
				`LKCAL_OFS_DELAY: delay_reg <= (delay_reg & ~be_mask[DELAY_W-1:0])
					| (avs_writedata_i[DELAY_W-1:0] & be_mask[DELAY_W-1:0]); // RULE3
				`LKCAL_OFS_START: start_reg <= (start_reg & ~be_mask) | (avs_writedata_i & be_mask);
				`LKCAL_OFS_FORCE: force_reg <= (force_reg & ~be_mask) | (avs_writedata_i & be_mask);
				`LKCAL_OFS_RBSEL: if (avs_byteenable_i[0]) begin
					rbsel_reg <= avs_writedata_i[3:0];
				end
				default: ;
			endcase
		end
	end

	// =========================================
	// Pin input synchronisers
	// =========================================
	// Three stages; a level is accepted only when stages two and three agree
	always @(posedge clk_i) begin
		if (rst_i) begin
			fast_sync_reg <= 3'h0;
			amp_sync_reg <= 3'h0;
			vt_sync_reg <= 3'h0;
			fast_reg <= 1'b0;
			amp_hi_reg <= 1'b0;
			vt_reg <= 1'b0;
		end else begin
			fast_sync_reg <= {fast_sync_reg[1:0], osc_fast_i};
			amp_sync_reg <= {amp_sync_reg[1:0], amp_high_i};
			vt_sync_reg <= {vt_sync_reg[1:0], vtune_lock_i};
			if (fast_sync_reg[1] == fast_sync_reg[2]) begin
				fast_reg <= fast_sync_reg[2];
			end
			if (amp_sync_reg[1] == amp_sync_reg[2]) begin
				amp_hi_reg <= amp_sync_reg[2];
			end
			if (vt_sync_reg[1] == vt_sync_reg[2]) begin
				vt_reg <= vt_sync_reg[2];
			end
		end
	end

	// =========================================
	// State machine tick
	// =========================================
	// Tick every 2^div reference cycles instead of a gated second clock
	assign div_sel = cfg_reg[`LKCAL_DIV_LSB +: 2];
	assign tick = (div_cnt_reg[2:0] & ((3'h1 << div_sel) - 3'h1)) == 3'h0; // RULE19
	// Search may act only once the comparators show the applied code
	assign settled = tick && (settle_reg == 4'h0);

	always @(posedge clk_i) begin
		if (rst_i) begin
			div_cnt_reg <= 3'h0;
		end else begin
			div_cnt_reg <= div_cnt_reg + 3'h1;
		end
	end

	// =========================================
	// Calibration engine
	// =========================================
	assign all_force = cfg_reg[`LKCAL_CORE_F_BIT] & cfg_reg[`LKCAL_AMP_F_BIT]
		& cfg_reg[`LKCAL_CAP_F_BIT];

	// A write to control zero restarts everything, even mid-calibration
	always @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= ST_IDLE;
			cal_busy_o <= 1'b0;
			steps_reg <= 9'h000;
			dir_reg <= 1'b0;
			first_reg <= 1'b0;
			settle_reg <= 4'h0;
			osc_core_o <= start_reg[`LKCAL_CORE_LSB +: CORE_W];
			osc_capcode_o <= start_reg[`LKCAL_CAP_LSB +: CAP_W];
			osc_amplitude_o <= start_reg[`LKCAL_AMP_LSB +: AMP_W];
		end else if (wr_ok && reg_idx == `LKCAL_OFS_CTRL0) begin
			steps_reg <= 9'h000;
			// Comparators still reflect the old code; stale readings would end the search
			settle_reg <= `LKCAL_SETTLE;
			first_reg <= 1'b1;
			if (all_force) begin
				osc_core_o <= force_reg[`LKCAL_CORE_LSB +: CORE_W]; // RULE17
				osc_capcode_o <= force_reg[`LKCAL_CAP_LSB +: CAP_W];
				osc_amplitude_o <= force_reg[`LKCAL_AMP_LSB +: AMP_W];
				state_reg <= ST_IDLE;
				cal_busy_o <= 1'b0;
			end else begin
				if (!cfg_reg[`LKCAL_QUICK_BIT]) begin
					osc_core_o <= start_reg[`LKCAL_CORE_LSB +: CORE_W]; // RULE12
					osc_capcode_o <= start_reg[`LKCAL_CAP_LSB +: CAP_W];
				end // RULE16
				osc_amplitude_o <= start_reg[`LKCAL_AMP_LSB +: AMP_W];
				cal_busy_o <= 1'b1;
				if (avs_writedata_i[`LKCAL_CAL_EN_BIT] && avs_byteenable_i[0]) begin
					state_reg <= ST_FREQ; // RULE9
				end else begin
					state_reg <= ST_AMP; // RULE10
				end
			end
		end else begin
			// Settling time runs on the reference clock, not on the tick
			if (settle_reg != 4'h0) begin
				settle_reg <= settle_reg - 4'h1;
			end
			if (settled) begin
				case (state_reg)
					ST_FREQ: begin
						// Band search; first settled reading fixes the direction
						steps_reg <= steps_reg + 9'h001;
						if ((!first_reg && fast_reg != dir_reg)
							|| steps_reg == `LKCAL_STEP_LIMIT
							|| (fast_reg && osc_capcode_o == {CAP_W{1'b1}})
							|| (!fast_reg && osc_capcode_o == {CAP_W{1'b0}})) begin
							state_reg <= ST_AMP;
							steps_reg <= 9'h000;
						end else begin
							dir_reg <= fast_reg;
							first_reg <= 1'b0;
							settle_reg <= `LKCAL_SETTLE;
							if (fast_reg) begin
								osc_capcode_o <= osc_capcode_o + {{(CAP_W-1){1'b0}}, 1'b1};
							end else begin
								osc_capcode_o <= osc_capcode_o - {{(CAP_W-1){1'b0}}, 1'b1};
							end
						end
					end
					ST_AMP: begin
						// Amplitude walks down until the detector clears
						steps_reg <= steps_reg + 9'h001;
						if (!amp_hi_reg || steps_reg == `LKCAL_STEP_LIMIT
							|| osc_amplitude_o == {AMP_W{1'b0}}) begin
							state_reg <= ST_IDLE;
							cal_busy_o <= 1'b0;
						end else begin
							settle_reg <= `LKCAL_SETTLE;
							osc_amplitude_o <= osc_amplitude_o - {{(AMP_W-1){1'b0}}, 1'b1};
						end
					end
					ST_IDLE: cal_busy_o <= 1'b0;
					default: begin
						state_reg <= ST_IDLE;
						cal_busy_o <= 1'b0;
					end
				endcase
			end
		end
	end

	// =========================================
	// Lock delay and lock indication
	// =========================================
	// Delay starts when the search ends; any new trigger resets it
	always @(posedge clk_i) begin
		if (rst_i) begin
			dcount_reg <= {DELAY_W{1'b0}};
			drun_reg <= 1'b0;
		end else if (wr_ok && reg_idx == `LKCAL_OFS_CTRL0) begin
			dcount_reg <= {DELAY_W{1'b0}}; // RULE21
			drun_reg <= ~all_force & (delay_reg != {DELAY_W{1'b0}});
		end else if (tick && cal_busy_o) begin
			dcount_reg <= {DELAY_W{1'b0}};
		end else if (tick && drun_reg) begin
			if (dcount_reg == delay_reg - {{(DELAY_W-1){1'b0}}, 1'b1}) begin
				drun_reg <= 1'b0; // RULE3 RULE4
			end
			dcount_reg <= dcount_reg + {{(DELAY_W-1){1'b0}}, 1'b1};
		end
	end

	// Type 0 follows calibration, type 1 follows the tuning monitor
	assign lock_ind = cfg_reg[`LKCAL_LOCK_DETECT_TYPE_BIT] ? vt_reg
		: ~(cal_busy_o | drun_reg); // RULE2 RULE4 RULE6
	assign lock_state = lock_ind ? `LKCAL_LOCK_STATE_YES : `LKCAL_LOCK_STATE_NO; // RULE6

	// Mute follows lock with one register stage
	always @(posedge clk_i) begin
		if (rst_i) begin
			out_mute_o <= 1'b0;
		end else begin
			out_mute_o <= cfg_reg[`LKCAL_MUTE_BIT] & ~lock_ind; // RULE5
		end
	end

	// =========================================
	// Serial readback and status pin
	// =========================================
	// Writing the select register loads that word; shifted MSB first per tick
	always @(posedge clk_i) begin
		if (rst_i) begin
			shift_reg <= 32'h0000_0000;
			shift_cnt_reg <= 6'h00;
		end else if (wr_ok && reg_idx == `LKCAL_OFS_RBSEL) begin
			shift_cnt_reg <= 6'h20;
			case (avs_writedata_i[3:0])
				`LKCAL_OFS_CTRL0: shift_reg <= {31'h0, ctrl0_reg};
				`LKCAL_OFS_CFG: shift_reg <= cfg_reg;
				`LKCAL_OFS_DELAY: shift_reg <= {{(32-DELAY_W){1'b0}}, delay_reg};
				`LKCAL_OFS_START: shift_reg <= start_reg;
				`LKCAL_OFS_FORCE: shift_reg <= force_reg;
				`LKCAL_OFS_STATUS: shift_reg <= {7'h0, osc_amplitude_o, osc_capcode_o,
					1'b0, osc_core_o, drun_reg, cal_busy_o, lock_state}; // RULE8
				default: shift_reg <= 32'h0000_0000;
			endcase
		end else if (tick && shift_cnt_reg != 6'h00) begin
			shift_reg <= {shift_reg[30:0], 1'b0};
			shift_cnt_reg <= shift_cnt_reg - 6'h01;
		end
	end

	// Pin registered so it never glitches on the mux change
	always @(posedge clk_i) begin
		if (rst_i) begin
			status_pin_o <= 1'b0;
		end else if (cfg_reg[`LKCAL_PIN_SEL_BIT]) begin
			status_pin_o <= lock_ind; // RULE1 RULE7
		end else begin
			status_pin_o <= (shift_cnt_reg != 6'h00) & shift_reg[31]; // RULE1 RULE8
		end
	end

endmodule // lkcal_top

// file: verification/lkcal_top_sva.sv
`timescale 1ns/1ps
// ======================================
// Bus handshake and search step checks
module lkcal_top_sva #(parameter DELAY_W = 16, parameter AMP_W = 9, parameter CAP_W = 8,
	parameter CORE_W = 3) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic [CORE_W-1:0] osc_core_o,
	input wire logic [CAP_W-1:0] osc_capcode_o,
	input wire logic [AMP_W-1:0] osc_amplitude_o,
	input wire logic cal_busy_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Request phases; a trigger write reloads the search, so skip that edge
	sequence s_first; (avs_read_i || avs_write_i) && avs_waitrequest_o; endsequence
	sequence s_done; (avs_read_i || avs_write_i) && !avs_waitrequest_o; endsequence
	sequence s_search; cal_busy_o && $past(cal_busy_o) && !$past(avs_write_i); endsequence
	a_wait_one: assert property (s_first |=> !avs_waitrequest_o)
		else $error("wait state longer than one cycle");
	a_wait_first: assert property (s_done |-> $past(avs_waitrequest_o))
		else $error("request answered without wait state");
	a_unmapped_zero: assert property (avs_read_i && avs_waitrequest_o
		&& avs_address_i[4:2] == 3'h7 |=> avs_readdata_o == 32'h0)
		else $error("unmapped read not zero");
	a_read_hold: assert property (!avs_read_i |=> $stable(avs_readdata_o))
		else $error("read data moved without a read");
	a_cal_start: assert property ($rose(cal_busy_o) |->
		$past(avs_write_i && !avs_waitrequest_o && avs_address_i[4:2] == 3'h0))
		else $error("search began without trigger write");
	a_core_hold: assert property (s_search |-> $stable(osc_core_o))
		else $error("core moved during search");
	a_cap_step: assert property (s_search |-> osc_capcode_o == $past(osc_capcode_o)
		|| osc_capcode_o == $past(osc_capcode_o) + 1'b1
		|| osc_capcode_o + 1'b1 == $past(osc_capcode_o))
		else $error("capcode stepped by more than one");
	a_amp_fall: assert property (s_search |-> osc_amplitude_o <= $past(osc_amplitude_o))
		else $error("amplitude rose during search");
endmodule // lkcal_top_sva
bind lkcal_top lkcal_top_sva #(.DELAY_W(DELAY_W), .AMP_W(AMP_W), .CAP_W(CAP_W),
	.CORE_W(CORE_W)) u_sva (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
	.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o), .osc_core_o(osc_core_o),
	.osc_capcode_o(osc_capcode_o), .osc_amplitude_o(osc_amplitude_o), .cal_busy_o(cal_busy_o));

// file: verification/lkcal_osc_model.sv
`timescale 1ns/1ps
// ======================================
// Oscillator comparators seen by the search
module lkcal_osc_model (
	input wire logic clk_i,
	input wire logic [7:0] osc_capcode_i,
	input wire logic [8:0] osc_amplitude_i,
	input wire logic [7:0] cap_target_i,
	input wire logic [8:0] amp_target_i,
	output logic osc_fast_o,
	output logic amp_high_o
);
	// Registered, so the search sees a one-cycle late comparator like silicon
	always @(posedge clk_i) begin
		osc_fast_o <= osc_capcode_i < cap_target_i;
		amp_high_o <= osc_amplitude_i > amp_target_i;
	end
endmodule // lkcal_osc_model

// file: verification/test_lkcal_top.sv
`timescale 1ns/1ps
module test_lkcal_top;
	logic clk_i = 0, rst_i = 1, avs_read_i = 0, avs_write_i = 0, vtune_lock_i = 0;
	logic [4:0] avs_address_i = 5'h00;
	logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q, val, rnd = 32'h34fa;
	logic [7:0] cap_t = 8'h6e, cx;
	logic [8:0] amp_t = 9'h122;
	logic [2:0] core_o;
	logic [7:0] cap_o;
	logic [8:0] amp_o;
	logic [43:0] sh;
	logic fast, ahigh, wr_o, busy_o, mute_o, pin_o;
	logic [3:0] be = 4'hf;
	int n_fail = 0, total_checks = 0, d, cnt;
	// ======================================
	// Clock, design and oscillator model
	always #2 clk_i = ~clk_i;
	lkcal_top DUT (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(be), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(wr_o),
		.osc_fast_i(fast), .amp_high_i(ahigh), .vtune_lock_i(vtune_lock_i), .osc_core_o(core_o),
		.osc_capcode_o(cap_o), .osc_amplitude_o(amp_o), .cal_busy_o(busy_o),
		.out_mute_o(mute_o), .status_pin_o(pin_o));
	lkcal_osc_model u_osc (.clk_i(clk_i), .osc_capcode_i(cap_o), .osc_amplitude_i(amp_o),
		.cap_target_i(cap_t), .amp_target_i(amp_t), .osc_fast_o(fast), .amp_high_o(ahigh));
	// ======================================
	// Helpers
	function automatic [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input [31:0] got, input [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic stop_test;
		$display("checks=%0d mismatches=%0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// Request held until waitrequest is seen low at a rising edge
	task automatic bus(input wr, input [4:0] a, input [31:0] dat, output [31:0] rd);
		avs_read_i <= !wr;
		avs_write_i <= wr;
		avs_address_i <= a;
		avs_writedata_i <= dat;
		@(posedge clk_i);
		while (wr_o !== 1'b0) @(posedge clk_i);
		rd = avs_readdata_o;
		avs_read_i <= 0;
		avs_write_i <= 0;
		@(posedge clk_i);
	endtask
	// Cycles until the pin rises, with an upper bound
	task automatic pin_wait;
		cnt = 0;
		while (pin_o !== 1'b1 && cnt < 4000) begin
			@(negedge clk_i);
			cnt++;
		end
		if (cnt >= 4000) n_fail++;
	endtask
	initial begin
		repeat (30000) @(posedge clk_i);
		n_fail++;
		stop_test;
	end
	// ======================================
	// Test sequence
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		bus(0, 5'h0c, 0, q); chk(q, 32'h012c_b707);
		chk({core_o, cap_o, amp_o}, {3'h7, 8'hb7, 9'h12c});
		bus(0, 5'h1c, 0, q); chk(q, 32'h0);
		$display("test reset done");
		// Forced values applied directly, no search
		rnd = lfsr(rnd);
		val = rnd & 32'h01ff_ff07;
		bus(1, 5'h10, val, q);
		bus(1, 5'h04, 32'h0000_0e01, q);
		bus(1, 5'h00, 32'h1, q);
		repeat (2) @(negedge clk_i);
		chk({core_o, cap_o, amp_o}, {val[2:0], val[15:8], val[24:16]});
		chk(busy_o, 0);
		$display("test force done");
		// Search with lock delay, both trigger kinds and four divides
		for (int k = 0; k < 4; k++) begin
			rnd = lfsr(rnd);
			d = rnd[3:0] + 2;
			bus(1, 5'h04, 32'h5 | (k << 4), q);
			bus(1, 5'h08, d, q);
			bus(1, 5'h0c, 32'h012c_0104, q);
			bus(1, 5'h00, {31'h0, !k[0]}, q);
			@(negedge clk_i); chk(busy_o, 1);
			@(negedge clk_i); chk({pin_o, mute_o}, 2'b01);
			cnt = 0;
			while (busy_o !== 1'b0 && cnt < 4000) begin
				@(negedge clk_i);
				cnt++;
			end
			if (cnt >= 4000) n_fail++;
			chk(core_o, 3'h4);
			chk(amp_o <= 9'h122 && amp_o >= 9'h11e, 1);
			chk(k[0] ? cap_o == 8'h01 : cap_o >= 8'h6d && cap_o <= 8'h70, 1);
			pin_wait;
			chk(cnt >= (d << k) && cnt <= ((d + 3) << k) + 4, 1);
			chk(mute_o, 0);
		end
		$display("test search done");
		// Quick recalibration keeps the present capcode
		cx = cap_o;
		bus(1, 5'h0c, 32'h012c_b707, q);
		bus(1, 5'h04, 32'h0000_0101, q);
		bus(1, 5'h00, 32'h1, q);
		@(negedge clk_i); chk(cap_o, cx);
		pin_wait;
		$display("test quick done");
		// Tuning monitor lock, with and without mute
		for (int m = 0; m < 2; m++) begin
			bus(1, 5'h04, 32'h3 | (m << 2), q);
			vtune_lock_i <= 1;
			repeat (10) @(negedge clk_i);
			chk({pin_o, mute_o}, 2'b10);
			bus(0, 5'h14, 0, q); chk(q[1:0], 2'h2);
			@(posedge clk_i) vtune_lock_i <= 0;
			repeat (10) @(negedge clk_i);
			chk({pin_o, mute_o}, {1'b0, m[0]});
			bus(0, 5'h14, 0, q); chk(q[1:0], 2'h0);
		end
		$display("test vtune done");
		// Byte lane one alone reaches the configuration word
		be <= 4'h2;
		bus(1, 5'h04, 32'hffff_ffff, q);
		be <= 4'hf;
		bus(0, 5'h04, 0, q); chk(q, 32'h0000_ff07);
		// Register word shifted out on the pin
		rnd = lfsr(rnd);
		val = rnd & 32'h0000_0302;
		bus(1, 5'h04, val, q);
		bus(0, 5'h04, 0, q); chk(q, val);
		bus(1, 5'h18, 32'h1, q);
		for (int i = 0; i < 44; i++) begin
			@(negedge clk_i);
			sh = {sh[42:0], pin_o};
		end
		chk(sh[43:12], val);
		chk(pin_o, 0);
		$display("test readback done");
		stop_test;
	end
endmodule // test_lkcal_top
